// File: design/cp8_char_path.sv
// Purpose: 8B/10B transmit and receive character path with clock generation.
// Assumes: All pins but the asynchronous reset arst_n, including the reference clock, are sampled on core_clk.
// Notes: Serial side moves one bit per core clock, first bit a.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Half rate with reference capture takes transmit data on both reference edges.
// - Transmit clock runs at twice reference rate in half rate, else same; own duty at full rate only.
// - With reference selected, both receive clocks are delayed reference copies, phases differ.
// - In half rate, received characters launch on both receive clock edges.
// - Each byte is encoded to ten bits and shifted out serially.
// - Serial input is grouped in tens and data characters decoded back to bytes.
// - All 256 bytes are accepted as data; extra patterns are special characters.
// - Parallel bit 0 is letter A through bit 7 as letter H.
// - Bits a..h follow A..H; i comes from A..E, j from F..H.
// - Qualifier low marks data, high marks special, on both directions.
// - Name index xx is EDCBA, suffix y is HGF; specials take nearest data names.
// - Comma patterns in special characters set receive character alignment.
// - Serial bit order is a, b, c, d, e, i, f, g, h, j.
// - Running disparity updates over abcdei then fghj, carried between sub-blocks.
// - Transmit control bit 0 zero means data; receive status 000 means valid data.
module cp8_char_path (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic referenceClock,
  input wire logic transmitInputClock,
  input wire cp8_pkg::cp8_tx_t txIn,
  output logic transmitClockOutput,
  output logic serialOut,
  input wire logic serialIn,
  output logic receiveClockOutput,
  output logic receiveClockOutputAlt,
  output cp8_pkg::cp8_rx_t rxCharOut
);
  // ----------------------------------------------------------------
  // Coding functions
  // ----------------------------------------------------------------
  function automatic logic isK(input logic [7:0] d);
    return (d[4:0] == 5'h1C) || (d[7:5] == 3'h7 && (d[4:0] == 5'h17 || d[4:0] == 5'h1B ||
      d[4:0] == 5'h1D || d[4:0] == 5'h1E));
  endfunction

  function automatic logic nextRd(input logic [9:0] c, input logic rd);
    logic r;
    r = rd;
    if ($countones(c[9:4]) > 3 || c[9:4] == 6'h07)
      r = 1'b1;
    else if ($countones(c[9:4]) < 3 || c[9:4] == 6'h38)
      r = 1'b0;
    if ($countones(c[3:0]) > 2 || c[3:0] == 4'h3)
      r = 1'b1;
    else if ($countones(c[3:0]) < 2 || c[3:0] == 4'hC)
      r = 1'b0;
    return r;
  endfunction

  // Bits A..E index the six-bit table and F..H the four-bit one.
  function automatic logic [9:0] encode(input logic [7:0] d, input logic k, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic r6;
    logic alt;
    c6 = (k && d[4:0] == 5'h1C) ? cp8_pkg::CP8_K28_6B : cp8_pkg::CP8_TAB6[d[4:0]];
    if (rd && ($countones(c6) != 3 || c6 == 6'h38))
      c6 = ~c6;
    r6 = ($countones(c6) == 3) ? rd : ~rd;
    alt = (d[7:5] == 3'h7) && (k || (!r6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
      (r6 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D || d[4:0] == 5'h0E)));
    c4 = alt ? cp8_pkg::CP8_ALT7_4B : cp8_pkg::CP8_TAB4[d[7:5]];
    if (r6 && ($countones(c4) != 2 || c4 == 4'hC))
      c4 = ~c4;
    if (k && d[4:0] == 5'h1C && !r6 && $countones(c4) == 2 && c4 != 4'hC && c4 != 4'h3)
      c4 = ~c4;
    return {c6, c4};
  endfunction

  // Searching the encoder keeps both directions on one table at the cost of area.
  function automatic cp8_pkg::cp8_rx_t decode(input logic [9:0] c, input logic rd);
    cp8_pkg::cp8_rx_t r;
    logic [8:0] v;
    r = '{status: cp8_pkg::CP8_ST_VIOL, special: 1'b0, data: 8'h00};
    for (int i = 0; i < 512; i++)
    begin
      v = 9'(i);
      if ((!v[8] || isK(v[7:0])) && encode(v[7:0], v[8], rd) == c)
      begin
        r.status = v[8] ? cp8_pkg::CP8_ST_SPECIAL : cp8_pkg::CP8_ST_DATA;
        r.special = v[8];
        r.data = v[7:0];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cp8_pkg::cp8_state_t s_r;
  cp8_pkg::cp8_state_t s_nxt;
  logic refRise;
  logic refFall;
  logic half;
  logic capture;
  logic clkEdge;
  logic txLoad;
  logic [9:0] txCode;
  logic [9:0] rxWord;
  logic comma;
  logic rxDone;
  logic launch;
  logic [31:0] statWord;
  cp8_pkg::cp8_rx_t rxDec;
  cp8_pkg::cp8_rx_t txCheck;

  always_comb
  begin
    s_nxt = s_r;
    refRise = referenceClock && !s_r.refPrev;
    refFall = !referenceClock && s_r.refPrev;
    half = s_r.ctrl[cp8_pkg::CP8_HALF_BIT];
    s_nxt.refPrev = referenceClock;
    s_nxt.tinPrev = transmitInputClock;
    capture = s_r.ctrl[cp8_pkg::CP8_TXREF_BIT] ? (refRise || (half && refFall))
      : (transmitInputClock && !s_r.tinPrev);
    // The output edge rate comes from the reference, the fall point from half the last edge interval,
    // so at full rate the reference duty cycle never reaches the output; in half rate it does.
    clkEdge = half ? (refRise || refFall) : refRise;
    if (clkEdge)
    begin
      s_nxt.edgeCnt = 8'h01;
      s_nxt.halfIvl = {1'b0, s_r.edgeCnt[7:1]};
      s_nxt.transmit_input_clock = 1'b1;
    end
    else
    begin
      s_nxt.edgeCnt = (s_r.edgeCnt == 8'hFF) ? s_r.edgeCnt : s_r.edgeCnt + 8'h01;
      if (s_r.edgeCnt >= s_r.halfIvl)
        s_nxt.transmit_input_clock = 1'b0;
    end
    // Transmit: an idle comma character fills gaps between host characters.
    txCode = encode(s_r.txHold.data, s_r.txHold.ctrl[0] && isK(s_r.txHold.data), s_r.txRd);
    txCheck = decode(txCode, s_r.txRd);
    txLoad = s_r.txBit == cp8_pkg::CP8_LAST_BIT;
    if (txLoad)
    begin
      s_nxt.txShift = s_r.txPend ? txCode : encode(cp8_pkg::CP8_IDLE_BYTE, 1'b1, s_r.txRd);
      s_nxt.txRd = nextRd(s_nxt.txShift, s_r.txRd);
      s_nxt.txBit = 4'h0;
      s_nxt.txPend = 1'b0;
    end
    else
    begin
      s_nxt.txShift = {s_r.txShift[8:0], 1'b0};
      s_nxt.txBit = s_r.txBit + 4'h1;
    end
    if (capture)
    begin
      s_nxt.txHold = txIn;
      s_nxt.txPend = 1'b1;
    end
    // Receive: a comma in the window forces a character boundary.
    rxWord = {s_r.rxSh[8:0], serialIn};
    comma = rxWord[9:3] == cp8_pkg::CP8_COMMA_NEG || rxWord[9:3] == cp8_pkg::CP8_COMMA_POS;
    rxDone = comma || s_r.rxBit == cp8_pkg::CP8_LAST_BIT;
    rxDec = decode(rxWord, s_r.rxRd);
    s_nxt.rxSh = rxWord;
    if (rxDone)
    begin
      s_nxt.rxBit = 4'h0;
      s_nxt.rxPend = rxDec;
      s_nxt.rxRd = nextRd(rxWord, s_r.rxRd);
      if (comma)
        s_nxt.rxAligned = 1'b1;
      else if (rxDec.status == cp8_pkg::CP8_ST_VIOL)
        s_nxt.rxAligned = 1'b0;
    end
    else
      s_nxt.rxBit = s_r.rxBit + 4'h1;
    // Receive clocks: delayed reference copies, or a per-character toggle.
    if (s_r.ctrl[cp8_pkg::CP8_RXREF_BIT])
      s_nxt.rxClkA = s_r.refPrev;
    else if (rxDone)
      s_nxt.rxClkA = !s_r.rxClkA;
    s_nxt.rxClkC = s_r.rxClkA;
    launch = (s_nxt.rxClkA != s_r.rxClkA) && (half || !s_r.ctrl[cp8_pkg::CP8_RXREF_BIT] || s_nxt.rxClkA);
    if (launch)
      s_nxt.rxOut = s_r.rxPend;
    // Register slave.
    if (awvalid && awready)
    begin
      s_nxt.awHave = 1'b1;
      s_nxt.awAddr = awaddr;
    end
    if (wvalid && wready)
    begin
      s_nxt.wHave = 1'b1;
      s_nxt.wData = wdata;
      s_nxt.wStrb = wstrb;
    end
    if (s_r.awHave && s_r.wHave)
    begin
      s_nxt.awHave = 1'b0;
      s_nxt.wHave = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp = cp8_pkg::CP8_RESP_OK;
      if (s_r.awAddr == cp8_pkg::CP8_CTRL_OFS)
      begin
        if (s_r.wStrb[0])
          s_nxt.ctrl = s_r.wData[2:0];
      end
      else if (s_r.awAddr != cp8_pkg::CP8_STAT_OFS)
        s_nxt.bResp = cp8_pkg::CP8_RESP_ERR;
    end
    if (s_r.bValid && bready)
      s_nxt.bValid = 1'b0;
    statWord = 32'h0000_0000;
    statWord[cp8_pkg::CP8_ALIGN_BIT] = s_r.rxAligned;
    statWord[cp8_pkg::CP8_TXRD_BIT] = s_r.txRd;
    statWord[cp8_pkg::CP8_RXRD_BIT] = s_r.rxRd;
    statWord[cp8_pkg::CP8_RECEIVE_CHARACTER_STATUS_LSB +: 3] = s_r.rxPend.status;
    if (arvalid && arready)
    begin
      s_nxt.rValid = 1'b1;
      s_nxt.rResp = cp8_pkg::CP8_RESP_OK;
      s_nxt.rData = 32'h0000_0000;
      if (araddr == cp8_pkg::CP8_CTRL_OFS)
        s_nxt.rData = {29'h0000_0000, s_r.ctrl};
      else if (araddr == cp8_pkg::CP8_STAT_OFS)
        s_nxt.rData = statWord;
      else
        s_nxt.rResp = cp8_pkg::CP8_RESP_ERR;
    end
    else if (s_r.rValid && rready)
      s_nxt.rValid = 1'b0;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign awready = !s_r.awHave && !s_r.bValid;
  assign wready = !s_r.wHave && !s_r.bValid;
  assign arready = !s_r.rValid;
  assign bvalid = s_r.bValid;
  assign bresp = s_r.bResp;
  assign rvalid = s_r.rValid;
  assign rdata = s_r.rData;
  assign rresp = s_r.rResp;
  assign transmitClockOutput = s_r.transmit_input_clock;
  assign serialOut = s_r.txShift[9];
  assign receiveClockOutput = s_r.rxClkA;
  assign receiveClockOutputAlt = s_r.rxClkC;
  assign rxCharOut = s_r.rxOut;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence sq_shift;
    serialOut == $past(s_r.txShift[8]);
  endsequence
  sequence sq_loaded;
    s_r.txBit == 4'h0 ##1 s_r.txBit == 4'h1;
  endsequence

  property p_r01;
    half && s_r.ctrl[cp8_pkg::CP8_TXREF_BIT] && refFall |=> s_r.txPend && s_r.txHold == $past(txIn);
  endproperty
  a_r01: assert property (p_r01) else $error("falling reference edge did not capture");
  property p_r02;
    (half && refFall) or (!half && refRise) |=> transmitClockOutput;
  endproperty
  a_r02: assert property (p_r02) else $error("transmit clock did not rise on its edge");
  property p_r03;
    s_r.ctrl[cp8_pkg::CP8_RXREF_BIT] && $past(s_r.ctrl[cp8_pkg::CP8_RXREF_BIT]) |->
      receiveClockOutput == $past(referenceClock, 2) && receiveClockOutputAlt == $past(receiveClockOutput);
  endproperty
  a_r03: assert property (p_r03) else $error("receive clocks are not reference copies");
  property p_r04;
    half && $fell(receiveClockOutput) |-> rxCharOut == $past(s_r.rxPend);
  endproperty
  a_r04: assert property (p_r04) else $error("no launch on falling receive clock");
  property p_r05;
    txLoad && s_r.txPend |=> s_r.txShift == $past(txCode) ##0 sq_loaded;
  endproperty
  a_r05: assert property (p_r05) else $error("encoded character not loaded");
  property p_r06;
    rxDone |=> s_r.rxPend == $past(rxDec) && s_r.rxBit == 4'h0;
  endproperty
  a_r06: assert property (p_r06) else $error("received group not decoded");
  property p_r07;
    txLoad && s_r.txPend && !s_r.txHold.ctrl[0] |-> txCheck.status == cp8_pkg::CP8_ST_DATA &&
      txCheck.data == s_r.txHold.data;
  endproperty
  a_r07: assert property (p_r07) else $error("data byte does not round trip");
  property p_r12;
    comma |=> s_r.rxBit == 4'h0 && s_r.rxAligned;
  endproperty
  a_r12: assert property (p_r12) else $error("comma did not align the receiver");
  property p_r13;
    !txLoad |=> sq_shift;
  endproperty
  a_r13: assert property (p_r13) else $error("serial bit out of order");
  property p_r14;
    txLoad |=> s_r.txRd == nextRd(s_r.txShift, $past(s_r.txRd));
  endproperty
  a_r14: assert property (p_r14) else $error("transmit disparity not updated");
  property p_r15;
    rxDone && rxDec.status != cp8_pkg::CP8_ST_VIOL && !rxDec.special |=> s_r.rxPend.status == 3'h0;
  endproperty
  a_r15: assert property (p_r15) else $error("valid data status is not zero");
endmodule
`default_nettype wire

// File: design/cp8_pkg.sv
// Purpose: Constants and carrier types for the 8B/10B character path.
// Assumes: One 100 MHz core clock and AXI4-Lite register access.
// Notes: Register offsets are byte addresses.
package cp8_pkg;
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam logic [31:0] CP8_CTRL_OFS = 32'h0000_0000;
  localparam logic [31:0] CP8_STAT_OFS = 32'h0000_0004;
  localparam int CP8_HALF_BIT = 0;
  localparam int CP8_TXREF_BIT = 1;
  localparam int CP8_RXREF_BIT = 2;
  localparam int CP8_ALIGN_BIT = 0;
  localparam int CP8_TXRD_BIT = 1;
  localparam int CP8_RXRD_BIT = 2;
  localparam int CP8_RECEIVE_CHARACTER_STATUS_LSB = 4;
  localparam logic [1:0] CP8_RESP_OK = 2'h0;
  localparam logic [1:0] CP8_RESP_ERR = 2'h2;
  // ----------------------------------------------------------------
  // Character coding
  // ----------------------------------------------------------------
  localparam logic [2:0] CP8_ST_DATA = 3'h0;
  localparam logic [2:0] CP8_ST_SPECIAL = 3'h1;
  localparam logic [2:0] CP8_ST_VIOL = 3'h2;
  localparam logic [7:0] CP8_IDLE_BYTE = 8'hBC;
  localparam logic [6:0] CP8_COMMA_NEG = 7'h1F;
  localparam logic [6:0] CP8_COMMA_POS = 7'h60;
  localparam logic [3:0] CP8_LAST_BIT = 4'h9;
  localparam logic [5:0] CP8_K28_6B = 6'h0F;
  localparam logic [3:0] CP8_ALT7_4B = 4'h7;
  localparam logic [5:0] CP8_TAB6 [32] = '{6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17, 6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B,
    6'h2A, 6'h1A, 6'h3A, 6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] CP8_TAB4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  typedef struct packed {logic [1:0] ctrl; logic [7:0] data;} cp8_tx_t;
  typedef struct packed {logic [2:0] status; logic special; logic [7:0] data;} cp8_rx_t;
  typedef struct packed {
    logic [2:0] ctrl; logic refPrev; logic tinPrev; logic [7:0] edgeCnt; logic [7:0] halfIvl;
    logic transmit_input_clock; cp8_tx_t txHold; logic txPend; logic txRd; logic [9:0] txShift; logic [3:0] txBit;
    logic [9:0] rxSh; logic [3:0] rxBit; logic rxAligned; logic rxRd; cp8_rx_t rxPend; cp8_rx_t rxOut;
    logic rxClkA; logic rxClkC; logic awHave; logic [31:0] awAddr; logic wHave; logic [31:0] wData;
    logic [3:0] wStrb; logic bValid; logic [1:0] bResp; logic rValid; logic [31:0] rData; logic [1:0] rResp;
  } cp8_state_t;
endpackage

// File: verification/cp8_host_model.sv
// Purpose: Host logic model on the parallel character side.
// Assumes: Pins change by non-blocking assignment after core_clk rising edges.
// Notes: Each character is held 21 cycles, over twice a character slot, so no capture is lost.
`timescale 1ns/1ps
`default_nettype none
module cp8_host_model (
  input wire logic core_clk,
  input wire logic receiveClockOutput,
  input wire cp8_pkg::cp8_rx_t rxCharOut,
  output logic referenceClock,
  output logic transmitInputClock,
  output cp8_pkg::cp8_tx_t txIn
);
  cp8_pkg::cp8_rx_t rxQ[$];
  logic rcoPrev = 1'h0;
  initial
  begin
    referenceClock = 1'h0;
    transmitInputClock = 1'h0;
    txIn = '0;
  end
  // ----------------------------------------------------------------
  // Receive capture
  // ----------------------------------------------------------------
  // Both clock edges are used, since half rate launches a character on each.
  always @(posedge core_clk)
  begin
    rcoPrev <= receiveClockOutput;
    if (receiveClockOutput !== rcoPrev)
    begin
      rxQ.push_back(rxCharOut);
    end
  end
  // ----------------------------------------------------------------
  // Transmit drive
  // ----------------------------------------------------------------
  task automatic send(input logic k, input logic [7:0] b, input bit viaRef);
    @(posedge core_clk);
    txIn <= {1'h0, k, b};
    if (viaRef)
    begin
      referenceClock <= ~referenceClock;
    end
    else
    begin
      transmitInputClock <= 1'h1;
    end
    repeat (5) @(posedge core_clk);
    transmitInputClock <= 1'h0;
    repeat (15) @(posedge core_clk);
  endtask
  task automatic refRun(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      referenceClock <= ~referenceClock;
      repeat (19) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// File: verification/tb_char_path_8b10b_mapping.sv
// Purpose: Self-checking bench for the character path, serial side looped back.
// Assumes: Byte queue model; the serial output feeds the serial input.
// Notes: Idle fillers give the receiver its comma for alignment.
`timescale 1ns/1ps
`default_nettype none
module tb_char_path_8b10b_mapping;
  logic core_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic referenceClock, transmitInputClock, transmitClockOutput, serialOut;
  logic receiveClockOutput, receiveClockOutputAlt;
  cp8_pkg::cp8_tx_t txIn;
  cp8_pkg::cp8_rx_t rxCharOut;
  int failures = 0, comparisons = 0, cyc = 0, tcoR = 0, rcoR = 0, refR = 0, diffN = 0;
  logic [9:0] win = 10'h0;
  logic tcoP = 1'h0, rcoP = 1'h0, refP = 1'h0;
  logic [7:0] expQ[$];
  always #5 core_clk = ~core_clk;
  cp8_char_path dut (.core_clk(core_clk), .arst_n(arst_n), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .referenceClock(referenceClock),
    .transmitInputClock(transmitInputClock), .txIn(txIn), .transmitClockOutput(transmitClockOutput),
    .serialOut(serialOut), .serialIn(serialOut), .receiveClockOutput(receiveClockOutput),
    .receiveClockOutputAlt(receiveClockOutputAlt), .rxCharOut(rxCharOut));
  cp8_host_model host (.core_clk(core_clk), .receiveClockOutput(receiveClockOutput), .rxCharOut(rxCharOut),
    .referenceClock(referenceClock), .transmitInputClock(transmitInputClock), .txIn(txIn));
  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    win <= {win[8:0], serialOut};
    tcoP <= transmitClockOutput;
    rcoP <= receiveClockOutput;
    refP <= referenceClock;
    if (transmitClockOutput && !tcoP) tcoR++;
    if (receiveClockOutput && !rcoP) rcoR++;
    if (referenceClock && !refP) refR++;
    if (receiveClockOutputAlt !== receiveClockOutput) diffN++;
    cyc++;
    // The ceiling is several times the expected run, so only a hang reaches it.
    if (cyc == 30000)
    begin
      failures++;
      final_report();
    end
  end
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string w);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t %s got %h exp %h", $time, w, got, exp);
    end
  endtask
  task automatic chkNear(input int got, input int exp, input string w);
    comparisons++;
    if (got > exp + 1 || got < exp - 1)
    begin
      failures++;
      $display("BAD t=%0t %s got %0d exp %0d", $time, w, got, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic axiWr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axiRd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  // Every data entry must match the queue in order; fillers must be clean specials.
  task automatic checkRx();
    cp8_pkg::cp8_rx_t e;
    repeat (60) @(posedge core_clk);
    while (host.rxQ.size() > 0)
    begin
      e = host.rxQ.pop_front();
      if (e.special === 1'h0 && expQ.size() > 0)
        chk(34'(e), 34'({cp8_pkg::CP8_ST_DATA, 1'h0, expQ.pop_front()}), "rx data");
      else
        chk(34'(e), 34'({cp8_pkg::CP8_ST_SPECIAL, 1'h1, 8'hBC}), "rx special");
    end
    chk(34'(expQ.size()), 34'h0, "rx missing");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [1:0] r;
    logic [31:0] d;
    logic [7:0] v;
    int a0, c0, e0, hit, seedV;
    {awaddr, wdata, araddr, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
    seedV = $urandom(32'hFFA4026C);
    repeat (16) @(posedge core_clk);
    arst_n <= 1'h1;
    axiRd(cp8_pkg::CP8_CTRL_OFS, d, r);
    chk({r, d}, {cp8_pkg::CP8_RESP_OK, 32'h0}, "ctrl reset");
    axiWr(cp8_pkg::CP8_CTRL_OFS, 32'h7, r);
    axiRd(cp8_pkg::CP8_CTRL_OFS, d, r);
    chk({r, d}, {cp8_pkg::CP8_RESP_OK, 32'h7}, "ctrl rw");
    axiWr(cp8_pkg::CP8_STAT_OFS, 32'hFF, r);
    chk(34'(r), 34'(cp8_pkg::CP8_RESP_OK), "stat write");
    axiRd(32'h10, d, r);
    chk({r, d}, {cp8_pkg::CP8_RESP_ERR, 32'h0}, "unmapped read");
    axiWr(32'h10, 32'h1, r);
    chk(34'(r), 34'(cp8_pkg::CP8_RESP_ERR), "unmapped write");
    $display("test registers done");
    axiWr(cp8_pkg::CP8_CTRL_OFS, 32'h0, r);
    repeat (100) @(posedge core_clk);
    axiRd(cp8_pkg::CP8_STAT_OFS, d, r);
    chk(34'(d[cp8_pkg::CP8_ALIGN_BIT]), 34'h1, "aligned");
    host.rxQ.delete();
    expQ.push_back(8'h45);
    hit = 0;
    // The character can leave the shifter before the send returns, so watch while sending.
    fork
      host.send(1'h0, 8'h45, 1'b0);
      repeat (40)
      begin
        @(posedge core_clk);
        if (win === 10'h295) hit = 1;
      end
    join
    chk(34'(hit), 34'h1, "serial pattern");
    checkRx();
    $display("test serial order done");
    for (int i = 0; i < 24; i++)
    begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      expQ.push_back(v);
      host.send(1'h0, v, 1'b0);
    end
    host.send(1'h1, 8'hBC, 1'b0);
    checkRx();
    $display("test loopback done");
    axiWr(cp8_pkg::CP8_CTRL_OFS, 32'h3, r);
    repeat (40) @(posedge core_clk);
    host.rxQ.delete();
    for (int i = 0; i < 16; i++)
    begin
      v = 8'($urandom);
      expQ.push_back(v);
      host.send(1'h0, v, 1'b1);
    end
    checkRx();
    $display("test half rate capture done");
    for (int m = 0; m < 2; m++)
    begin
      axiWr(cp8_pkg::CP8_CTRL_OFS, 32'(m), r);
      repeat (40) @(posedge core_clk);
      a0 = tcoR;
      c0 = refR;
      host.refRun(16);
      chkNear(tcoR - a0, (refR - c0) * (m + 1), "tx clock rate");
    end
    axiWr(cp8_pkg::CP8_CTRL_OFS, 32'h4, r);
    repeat (40) @(posedge core_clk);
    a0 = rcoR;
    c0 = refR;
    e0 = diffN;
    host.refRun(16);
    chkNear(rcoR - a0, refR - c0, "rx clock rate");
    chk(34'(diffN > e0), 34'h1, "rx clock phases");
    $display("test clocks done");
    final_report();
  end
endmodule
`default_nettype wire
